// *** pkg/bsp_pkg.sv ***
// constants, opcodes and tap state encoding of the boundary scan test port
package bsp_pkg;
	// ----------------------------------------
	// chain geometry
	// ----------------------------------------
	localparam int BSP_GROUPS = 2;
	localparam int BSP_FRAMERS_PER_GROUP = 8;
	localparam int BSP_IR_LEN = 2;

	// ----------------------------------------
	// instruction opcodes
	// ----------------------------------------
	typedef logic [BSP_IR_LEN-1:0] bsp_instr_t;
	localparam bsp_instr_t BSP_OP_EXTEST = 2'h0;
	localparam bsp_instr_t BSP_OP_SAMPLE = 2'h1;
	localparam bsp_instr_t BSP_OP_HIGHZ = 2'h2;
	localparam bsp_instr_t BSP_OP_BYPASS = 2'h3;
	localparam bsp_instr_t BSP_IR_CAPTURE = 2'h1;

	// ----------------------------------------
	// tap controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		BSP_TLR = 4'h0,
		BSP_RTI = 4'h1,
		BSP_SEL_DR = 4'h2,
		BSP_CAP_DR = 4'h3,
		BSP_SHIFT_DR = 4'h4,
		BSP_EXIT1_DR = 4'h5,
		BSP_PAUSE_DR = 4'h6,
		BSP_EXIT2_DR = 4'h7,
		BSP_UPD_DR = 4'h8,
		BSP_SEL_IR = 4'h9,
		BSP_CAP_IR = 4'hA,
		BSP_SHIFT_IR = 4'hB,
		BSP_EXIT1_IR = 4'hC,
		BSP_PAUSE_IR = 4'hD,
		BSP_EXIT2_IR = 4'hE,
		BSP_UPD_IR = 4'hF
	} bsp_tap_state_t;
endpackage

// *** core/bsp_tap_ctrl.sv ***
// sixteen-state tap controller stepped by the mode select on rising test clock
module bsp_tap_ctrl (
	// test link
	input wire logic tck,
	input wire logic test_reset_n,
	input wire logic tms,
	// state
	output bsp_pkg::bsp_tap_state_t state
);
	import bsp_pkg::*;

	bsp_tap_state_t next_state;

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			state <= BSP_TLR;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// transitions
	// ----------------------------------------
	always_comb begin
		unique case (state)
			BSP_TLR: next_state = tms ? BSP_TLR : BSP_RTI;
			BSP_RTI: next_state = tms ? BSP_SEL_DR : BSP_RTI;
			BSP_SEL_DR: next_state = tms ? BSP_SEL_IR : BSP_CAP_DR;
			BSP_CAP_DR: next_state = tms ? BSP_EXIT1_DR : BSP_SHIFT_DR;
			BSP_SHIFT_DR: next_state = tms ? BSP_EXIT1_DR : BSP_SHIFT_DR;
			BSP_EXIT1_DR: next_state = tms ? BSP_UPD_DR : BSP_PAUSE_DR;
			BSP_PAUSE_DR: next_state = tms ? BSP_EXIT2_DR : BSP_PAUSE_DR;
			BSP_EXIT2_DR: next_state = tms ? BSP_UPD_DR : BSP_SHIFT_DR;
			BSP_UPD_DR: next_state = tms ? BSP_SEL_DR : BSP_RTI;
			BSP_SEL_IR: next_state = tms ? BSP_TLR : BSP_CAP_IR;
			BSP_CAP_IR: next_state = tms ? BSP_EXIT1_IR : BSP_SHIFT_IR;
			BSP_SHIFT_IR: next_state = tms ? BSP_EXIT1_IR : BSP_SHIFT_IR;
			BSP_EXIT1_IR: next_state = tms ? BSP_UPD_IR : BSP_PAUSE_IR;
			BSP_PAUSE_IR: next_state = tms ? BSP_EXIT2_IR : BSP_PAUSE_IR;
			BSP_EXIT2_IR: next_state = tms ? BSP_UPD_IR : BSP_SHIFT_IR;
			BSP_UPD_IR: next_state = tms ? BSP_SEL_DR : BSP_RTI;
		endcase
	end
endmodule

// *** core/bsp_test_port.sv ***
// boundary scan test port with two scan chains and system bus output control
// How it works
// - each chain takes its serial input bit on rising test clock edges in the ir and dr shift states.
// - each serial output changes only on falling test clock edges.
// - a serial output is driven only while shifting and floats otherwise.
// - the low group input loads framers 1 to 8, the high group input framers 9 to 16.
// - the low group output returns framers 1 to 8, the high group output framers 9 to 16.
// - a low test reset puts the tap controller in its initial state.
// - the system bus output enable, when low, floats every receive and transmit bus output.
module bsp_test_port #(
	parameter int PER_GROUP = bsp_pkg::BSP_FRAMERS_PER_GROUP,
	parameter int GROUPS = bsp_pkg::BSP_GROUPS
) (
	// system clock and reset
	input wire logic clock,
	input wire logic rstn,
	// test link
	input wire logic tck,
	input wire logic test_reset_n,
	input wire logic tms,
	input wire logic scan_in_low_group,
	input wire logic scan_in_high_group,
	output logic scan_out_low_group,
	output logic scan_out_low_group_oe,
	output logic scan_out_high_group,
	output logic scan_out_high_group_oe,
	// system bus control and core data
	input wire logic system_bus_output_enable,
	input wire logic [GROUPS*PER_GROUP-1:0] receive_core_data,
	input wire logic [GROUPS*PER_GROUP-1:0] transmit_core_data,
	// system bus pins
	output logic [GROUPS*PER_GROUP-1:0] receive_system_bus,
	output logic [GROUPS*PER_GROUP-1:0] receive_system_bus_oe,
	output logic [GROUPS*PER_GROUP-1:0] transmit_system_bus,
	output logic [GROUPS*PER_GROUP-1:0] transmit_system_bus_oe
);
	import bsp_pkg::*;

	localparam int NFR = GROUPS * PER_GROUP;
	localparam int CELLS = 2 * PER_GROUP;

	bsp_tap_state_t state;
	logic [1:0] rst_pipe;
	logic rst_n_sync;
	logic [GROUPS-1:0] tdi_vec;
	logic [GROUPS-1:0] tdo_q;
	logic [GROUPS-1:0] tdo_oe_q;
	logic [GROUPS-1:0] next_tdo;
	logic [GROUPS-1:0] ext_flag;
	logic [GROUPS-1:0] hz_flag;
	logic [GROUPS-1:0] ext_meta;
	logic [GROUPS-1:0] ext_sync;
	logic [GROUPS-1:0] hz_meta;
	logic [GROUPS-1:0] hz_sync;
	logic [2*NFR-1:0] cap_meta;
	logic [2*NFR-1:0] cap_sync;
	logic upd_tog;
	logic tog_meta;
	logic tog_sync;
	logic tog_seen;
	logic upd_pulse;
	bsp_instr_t ir [GROUPS];
	bsp_instr_t ir_shift [GROUPS];
	logic [CELLS-1:0] bsr [GROUPS];
	logic [CELLS-1:0] upd [GROUPS];
	logic [CELLS-1:0] ext_word [GROUPS];
	logic [GROUPS-1:0] bypass_bit;
	logic [GROUPS-1:0] bsr_sel;
	logic any_ext_upd;

	// ----------------------------------------
	// system reset release
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n_sync = rst_pipe[1];

	// ----------------------------------------
	// tap controller
	// ----------------------------------------
	bsp_tap_ctrl u_tap (
		.tck(tck),
		.test_reset_n(test_reset_n),
		.tms(tms),
		.state(state)
	);

	assign tdi_vec = {scan_in_high_group, scan_in_low_group};

	// ----------------------------------------
	// pin values into the test clock domain
	// ----------------------------------------
	always_ff @(posedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			cap_meta <= '0;
			cap_sync <= '0;
		end else begin
			cap_meta <= {transmit_system_bus, receive_system_bus};
			cap_sync <= cap_meta;
		end
	end

	// ----------------------------------------
	// per group instruction and data registers
	// ----------------------------------------
	for (genvar g = 0; g < GROUPS; g++) begin : g_chain
		assign bsr_sel[g] = (ir[g] == BSP_OP_EXTEST) || (ir[g] == BSP_OP_SAMPLE);

		always_ff @(posedge tck or negedge test_reset_n) begin
			if (!test_reset_n) begin
				ir[g] <= BSP_OP_BYPASS;
				ir_shift[g] <= BSP_IR_CAPTURE;
				ext_flag[g] <= 1'b0;
				hz_flag[g] <= 1'b0;
			end else if (state == BSP_TLR) begin
				ir[g] <= BSP_OP_BYPASS;
				ext_flag[g] <= 1'b0;
				hz_flag[g] <= 1'b0;
			end else if (state == BSP_CAP_IR) begin
				ir_shift[g] <= BSP_IR_CAPTURE;
			end else if (state == BSP_SHIFT_IR) begin
				ir_shift[g] <= {tdi_vec[g], ir_shift[g][BSP_IR_LEN-1:1]};
			end else if (state == BSP_UPD_IR) begin
				ir[g] <= ir_shift[g];
				ext_flag[g] <= (ir_shift[g] == BSP_OP_EXTEST);
				hz_flag[g] <= (ir_shift[g] == BSP_OP_HIGHZ);
			end
		end

		always_ff @(posedge tck or negedge test_reset_n) begin
			if (!test_reset_n) begin
				bsr[g] <= '0;
				bypass_bit[g] <= 1'b0;
				upd[g] <= '0;
			end else if (state == BSP_CAP_DR) begin
				bsr[g] <= {cap_sync[NFR + g*PER_GROUP +: PER_GROUP],
					cap_sync[g*PER_GROUP +: PER_GROUP]};
				bypass_bit[g] <= 1'b0;
			end else if (state == BSP_SHIFT_DR) begin
				if (bsr_sel[g]) begin
					bsr[g] <= {tdi_vec[g], bsr[g][CELLS-1:1]};
				end else begin
					bypass_bit[g] <= tdi_vec[g];
				end
			end else if (state == BSP_UPD_DR && bsr_sel[g]) begin
				upd[g] <= bsr[g];
			end
		end

		// serial output selection
		always_comb begin
			if (state == BSP_SHIFT_IR) begin
				next_tdo[g] = ir_shift[g][0];
			end else if (bsr_sel[g]) begin
				next_tdo[g] = bsr[g][0];
			end else begin
				next_tdo[g] = bypass_bit[g];
			end
		end

		always_ff @(negedge tck or negedge test_reset_n) begin
			if (!test_reset_n) begin
				tdo_q[g] <= 1'b0;
				tdo_oe_q[g] <= 1'b0;
			end else begin
				tdo_q[g] <= next_tdo[g];
				tdo_oe_q[g] <= (state == BSP_SHIFT_IR) || (state == BSP_SHIFT_DR);
			end
		end
	end

	assign scan_out_low_group = tdo_q[0];
	assign scan_out_low_group_oe = tdo_oe_q[0];
	assign scan_out_high_group = tdo_q[1];
	assign scan_out_high_group_oe = tdo_oe_q[1];

	// ----------------------------------------
	// update event toward the system clock
	// ----------------------------------------
	assign any_ext_upd = (state == BSP_UPD_DR) && (|(ext_flag & bsr_sel));

	always_ff @(posedge tck or negedge test_reset_n) begin
		if (!test_reset_n) begin
			upd_tog <= 1'b0;
		end else if (any_ext_upd) begin
			upd_tog <= ~upd_tog;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_seen <= 1'b0;
			ext_meta <= '0;
			ext_sync <= '0;
			hz_meta <= '0;
			hz_sync <= '0;
		end else if (!rst_n_sync) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_seen <= 1'b0;
			ext_meta <= '0;
			ext_sync <= '0;
			hz_meta <= '0;
			hz_sync <= '0;
		end else begin
			tog_meta <= upd_tog;
			tog_sync <= tog_meta;
			tog_seen <= tog_sync;
			ext_meta <= ext_flag;
			ext_sync <= ext_meta;
			hz_meta <= hz_flag;
			hz_sync <= hz_meta;
		end
	end
	assign upd_pulse = tog_sync ^ tog_seen;

	// ----------------------------------------
	// system bus pins
	// ----------------------------------------
	for (genvar g = 0; g < GROUPS; g++) begin : g_word
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				ext_word[g] <= '0;
			end else if (upd_pulse) begin
				ext_word[g] <= upd[g];
			end
		end
	end

	for (genvar i = 0; i < NFR; i++) begin : g_pin
		always_ff @(posedge clock or negedge rstn) begin
			if (!rstn) begin
				receive_system_bus[i] <= 1'b0;
				transmit_system_bus[i] <= 1'b0;
				receive_system_bus_oe[i] <= 1'b0;
				transmit_system_bus_oe[i] <= 1'b0;
			end else if (!rst_n_sync) begin
				receive_system_bus[i] <= 1'b0;
				transmit_system_bus[i] <= 1'b0;
				receive_system_bus_oe[i] <= 1'b0;
				transmit_system_bus_oe[i] <= 1'b0;
			end else begin
				receive_system_bus[i] <= ext_sync[i / PER_GROUP] ?
					ext_word[i / PER_GROUP][i % PER_GROUP] : receive_core_data[i];
				transmit_system_bus[i] <= ext_sync[i / PER_GROUP] ?
					ext_word[i / PER_GROUP][PER_GROUP + i % PER_GROUP] : transmit_core_data[i];
				receive_system_bus_oe[i] <= system_bus_output_enable
					&& !hz_sync[i / PER_GROUP];
				transmit_system_bus_oe[i] <= system_bus_output_enable
					&& !hz_sync[i / PER_GROUP];
			end
		end
	end
endmodule

// *** tb/bsp_test_port_assertions.sv ***
// concurrent checks on the test port pins
module bsp_test_port_assertions #(
	parameter int PER_GROUP = 8,
	parameter int GROUPS = 2
) (
	// watched ports
	input wire logic clock,
	input wire logic rstn,
	input wire logic tck,
	input wire logic test_reset_n,
	input wire logic tms,
	input wire logic scan_out_low_group,
	input wire logic scan_out_low_group_oe,
	input wire logic scan_out_high_group_oe,
	input wire logic system_bus_output_enable,
	input wire logic [GROUPS*PER_GROUP-1:0] receive_system_bus_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// tap walks
	// ----------------------------------------
	sequence to_tlr;
		tms [*5];
	endsequence
	sequence to_shift_ir;
		!tms ##1 tms ##1 tms ##1 !tms ##1 !tms;
	endsequence

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_ir_entry: assert property (@(posedge tck) disable iff (!test_reset_n)
		to_tlr ##1 to_shift_ir |=> scan_out_low_group_oe && scan_out_high_group_oe)
		else $error("no drive in shift");
	chk_ir_capture: assert property (@(posedge tck) disable iff (!test_reset_n)
		to_tlr ##1 to_shift_ir ##1 !tms |-> scan_out_low_group ##1 !scan_out_low_group)
		else $error("bad ir capture");
	chk_exit_lo: assert property (@(posedge tck) disable iff (!test_reset_n)
		tms |=> !scan_out_low_group_oe)
		else $error("low out driven");
	chk_exit_hi: assert property (@(posedge tck) disable iff (!test_reset_n)
		tms |=> !scan_out_high_group_oe)
		else $error("high out driven");
	chk_oe_pair: assert property (@(posedge tck) disable iff (!test_reset_n)
		scan_out_low_group_oe == scan_out_high_group_oe)
		else $error("oe differ");
	chk_stable_out: assert property (@(posedge clock) disable iff (!rstn)
		tck && $past(tck) |-> $stable(scan_out_low_group))
		else $error("out moved high");
	chk_stable_oe: assert property (@(posedge clock) disable iff (!rstn)
		tck && $past(tck) |-> $stable(scan_out_high_group_oe))
		else $error("oe moved high");
	chk_trst_idle: assert property (@(posedge clock) disable iff (!rstn)
		!test_reset_n |-> !scan_out_low_group_oe && !scan_out_high_group_oe)
		else $error("oe in reset");
	chk_bus_float: assert property (@(posedge clock) disable iff (!rstn)
		!system_bus_output_enable |=> receive_system_bus_oe == '0)
		else $error("bus not floated");
endmodule

bind bsp_test_port bsp_test_port_assertions #(.PER_GROUP(PER_GROUP), .GROUPS(GROUPS)) chk_i (
	.clock, .rstn, .tck, .test_reset_n, .tms, .scan_out_low_group, .scan_out_low_group_oe,
	.scan_out_high_group_oe, .system_bus_output_enable, .receive_system_bus_oe);

// *** tb/bsp_jtag_host.sv ***
// test controller model driving the scan link
module bsp_jtag_host (
	// link out
	output logic tck,
	output logic tms,
	output logic tdi_l,
	output logic tdi_h,
	// link in
	input wire logic tdo_l,
	input wire logic tdo_h,
	input wire logic oe_l,
	input wire logic oe_h
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] s;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi_l = 1'b1;
		tdi_h = 1'b1;
	end
	// one tck period, clock still outside
	task automatic step(input logic m, input logic dl, input logic dh);
		tms = m;
		tdi_l = dl;
		tdi_h = dh;
		// floating outputs read back inverted
		#80 s = {oe_l ? tdo_l : !tdo_l, oe_h ? tdo_h : !tdo_h, oe_l, oe_h};
		tck = 1'b1;
		#80 tck = 1'b0;
	endtask
	// shift n bits through ir or dr from idle
	task automatic shift(input logic ir, input int n, input logic [15:0] il,
		input logic [15:0] ih, output logic [15:0] ol, output logic [15:0] oh, output logic ok);
		ol = '0;
		oh = '0;
		ok = 1'b1;
		#13;
		if (ir) begin
			repeat (5) step(1'b1, 1'b1, 1'b1);
			step(1'b0, 1'b1, 1'b1);
		end
		step(1'b1, 1'b1, 1'b1);
		if (ir)
			step(1'b1, 1'b1, 1'b1);
		step(1'b0, 1'b1, 1'b1);
		step(1'b0, 1'b1, 1'b1);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, il[i], ih[i]);
			ol[i] = s[3];
			oh[i] = s[2];
			ok = ok & s[1] & s[0];
		end
		step(1'b1, 1'b1, 1'b1);
		step(1'b0, 1'b1, 1'b1);
	endtask
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the test port
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import bsp_pkg::*;
	typedef struct packed {logic en; logic [15:0] r; logic [15:0] t; logic [15:0] oe;} bsp_row_t;
	logic clock, rstn, test_reset_n, sboe, tck, tms, tdi_l, tdi_h, tdo_l, tdo_h, oe_l, oe_h, ok;
	logic [15:0] rx_d, tx_d, rx_p, rx_oe, tx_p, tx_oe, ol, oh;
	int num_errors, cmp_count, cycles;
	bsp_row_t rows [3] = '{'{1'b1, 16'h0000, 16'hFFFF, 16'hFFFF},
		'{1'b0, 16'h1234, 16'h4321, 16'h0000}, '{1'b1, 16'hA5C3, 16'h3C5A, 16'hFFFF}};
	bsp_test_port bsp_test_port_i (.clock(clock), .rstn(rstn), .tck(tck),
		.test_reset_n(test_reset_n), .tms(tms), .scan_in_low_group(tdi_l),
		.scan_in_high_group(tdi_h), .scan_out_low_group(tdo_l), .scan_out_low_group_oe(oe_l),
		.scan_out_high_group(tdo_h), .scan_out_high_group_oe(oe_h),
		.system_bus_output_enable(sboe), .receive_core_data(rx_d),
		.transmit_core_data(tx_d), .receive_system_bus(rx_p), .receive_system_bus_oe(rx_oe),
		.transmit_system_bus(tx_p), .transmit_system_bus_oe(tx_oe));
	bsp_jtag_host bsp_jtag_host_i (.tck(tck), .tms(tms), .tdi_l(tdi_l), .tdi_h(tdi_h),
		.tdo_l(tdo_l), .tdo_h(tdo_h), .oe_l(oe_l), .oe_h(oe_h));
	task give_verdict;
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task settle(input int n);
		repeat (n) @(posedge clock);
		@(negedge clock);
	endtask
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial begin
		cycles = 0;
		forever begin
			@(posedge clock);
			cycles++;
			if (cycles == 6000) begin
				num_errors++;
				give_verdict;
			end
		end
	end
	initial begin
		{rstn, test_reset_n, sboe, rx_d, tx_d} = '0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		test_reset_n <= 1'b1;
		repeat (4) @(posedge clock);
		// ----------------------------------------
		// bus table
		// ----------------------------------------
		foreach (rows[i]) begin
			sboe <= rows[i].en;
			rx_d <= rows[i].r;
			tx_d <= rows[i].t;
			settle(1);
			`CHK({rx_oe, tx_oe}, {2{rows[i].oe}})
			if (rows[i].en)
				`CHK({rx_p, tx_p}, {rows[i].r, rows[i].t})
			@(posedge clock);
		end
		// ----------------------------------------
		// awkward cases
		// ----------------------------------------
		bsp_jtag_host_i.shift(1'b1, 2, 16'(BSP_OP_SAMPLE), 16'(BSP_OP_SAMPLE), ol, oh, ok);
		`CHK({ol[1:0], oh[1:0], ok}, {BSP_IR_CAPTURE, BSP_IR_CAPTURE, 1'b1})
		bsp_jtag_host_i.shift(1'b0, 16, 16'h1234, 16'hABCD, ol, oh, ok);
		`CHK({ol, oh, ok}, {16'h5AC3, 16'h3CA5, 1'b1})
		bsp_jtag_host_i.shift(1'b1, 2, 16'(BSP_OP_EXTEST), 16'(BSP_OP_EXTEST), ol, oh, ok);
		bsp_jtag_host_i.shift(1'b0, 16, 16'h1234, 16'hABCD, ol, oh, ok);
		settle(8);
		`CHK({rx_p, tx_p}, {16'hCD34, 16'hAB12})
		@(posedge clock);
		test_reset_n <= 1'b0;
		settle(1);
		`CHK({oe_l, oe_h}, 2'h0)
		@(posedge clock);
		test_reset_n <= 1'b1;
		settle(4);
		`CHK({rx_p, tx_p}, {16'hA5C3, 16'h3C5A})
		bsp_jtag_host_i.shift(1'b1, 2, 16'(BSP_OP_HIGHZ), 16'(BSP_OP_HIGHZ), ol, oh, ok);
		settle(6);
		`CHK({rx_oe, tx_oe}, 32'h0)
		bsp_jtag_host_i.shift(1'b1, 2, 16'(BSP_OP_BYPASS), 16'(BSP_OP_BYPASS), ol, oh, ok);
		bsp_jtag_host_i.shift(1'b0, 3, 16'h6, 16'h3, ol, oh, ok);
		`CHK({ol[2:0], oh[2:0]}, {3'h4, 3'h6})
		settle(6);
		`CHK({rx_oe, rx_p}, {16'hFFFF, 16'hA5C3})
		give_verdict;
	end
endmodule
